// ---- epi_pkg.sv ----
// Shared constants for both ends of the serial EEPROM pin link.
package epi_pkg;
   // ==========================================================
   // Data and timing
   // ==========================================================
   localparam int          EPI_BYTE_W    = 8;
   localparam int          EPI_CNT_W     = 3;
   localparam int          EPI_CLK_HZ    = 40000000;
   // Serial clock half period made by the host, in ns.
   localparam int          EPI_SCK_HALF_NS = 200;
   localparam int          EPI_SCK_HALF  =
      (EPI_SCK_HALF_NS * (EPI_CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [7:0]  EPI_HALF_CYC  = 8'(EPI_SCK_HALF);
   localparam logic [2:0]  EPI_LAST_BIT  = 3'h7;
   // Reset values of the pins and user ports.
   localparam logic        EPI_PIN_IDLE  = 1'b1;
   localparam logic [7:0]  EPI_BYTE_RST  = 8'h00;
   // Host sequencer states.
   typedef enum logic [2:0] {
      EPI_H_IDLE, EPI_H_LEAD, EPI_H_LOW, EPI_H_HIGH, EPI_H_NEXT,
      EPI_H_TAIL
   } epi_hstate_e;
endpackage

// ---- epi_if.sv ----
// Pin-level link between the serial master and the EEPROM end.
`timescale 1ns/1ps
interface epi_if;
   logic cs_n;      // Chip select, low selects.
   logic sck;       // Serial clock from the master.
   logic sdi;       // Data toward the device.
   logic hold_n;    // Pause request, low pauses.
   logic wp_n;      // Write protect, low protects.
   logic sdo_o;     // Device output value.
   logic sdo_oe;    // Device output enable, high drives.
   logic sdo;       // Resolved wire, pulled high when undriven.
   assign sdo = sdo_oe ? sdo_o : 1'b1;
   modport dev  (input cs_n, sck, sdi, hold_n, wp_n,
                 output sdo_o, sdo_oe);
   modport host (output cs_n, sck, sdi, hold_n, wp_n, input sdo);
endinterface

// ---- epi_dev.sv ----
// EEPROM end of the serial pin link, sampled on the device clock.
`timescale 1ns/1ps
module epi_dev
   import epi_pkg::*;
(
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   // Link pins
   epi_if.dev                             pins,
   // Received byte stream
   output logic [epi_pkg::EPI_BYTE_W-1:0] rx_data,
   output logic                           rx_valid,
   input  wire logic                      rx_ready,
   output logic                           rx_overrun,
   // Byte stream to shift out
   input  wire logic [epi_pkg::EPI_BYTE_W-1:0] tx_data,
   input  wire logic                      tx_valid,
   output logic                           tx_ready,
   // Rest of the device
   input  wire logic                      write_armed,
   input  wire logic                      write_busy,
   input  wire logic                      status_protect_enable,
   output logic                           write_start,
   output logic                           status_write_ok,
   output logic                           standby,
   output logic                           paused
);
   import epi_pkg::*;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [4:0] meta_q, sync_q;
   logic       sck_prev_q, cs_prev_q, hold_prev_q;
   logic       cs_s, sck_s, sdi_s, hold_s, wp_s;
   assign {cs_s, sck_s, sdi_s, hold_s, wp_s} = sync_q;

   // Two flip-flops on every pin before any logic reads it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Select resets low: a pin held low from power-up gives no fall.
         meta_q <= 5'h03;
         sync_q <= 5'h03;
      end else begin
         meta_q <= {pins.cs_n, pins.sck, pins.sdi, pins.hold_n,
                    pins.wp_n};
         sync_q <= meta_q;
      end
   end

   // Delayed copies for edge detection.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_q  <= 1'b0;
         cs_prev_q   <= 1'b0;
         hold_prev_q <= EPI_PIN_IDLE;
      end else begin
         sck_prev_q  <= sck_s;
         cs_prev_q   <= cs_s;
         hold_prev_q <= hold_s;
      end
   end

   logic cs_fall, cs_rise, sck_rise, sck_fall, hold_rise;
   assign cs_fall   = cs_prev_q & ~cs_s;
   assign cs_rise   = ~cs_prev_q & cs_s;
   assign sck_rise  = ~sck_prev_q & sck_s;
   assign sck_fall  = sck_prev_q & ~sck_s;
   assign hold_rise = ~hold_prev_q & hold_s;

   // ==========================================================
   // Selection and pause
   // ==========================================================
   logic active_q, paused_q, live;
   assign live = active_q & ~paused_q;

   // A select fall arms the link; a select rise drops it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 1'b0;
      end else if (cs_s) begin
         active_q <= 1'b0;
      end else if (cs_fall) begin
         active_q <= 1'b1;
      end
   end

   // Pause tracking; sequence state is left untouched meanwhile.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         paused_q <= 1'b0;
      end else if (!active_q) begin
         paused_q <= 1'b0;
      end else if (!paused_q) begin
         // A hold that falls with clock high waits for the fall.
         if (!hold_s && !sck_s) begin
            paused_q <= 1'b1;
         end
      end else if (hold_rise && !sck_s) begin
         paused_q <= 1'b0;
      end
   end

   // ==========================================================
   // Receive shifter
   // ==========================================================
   logic [EPI_CNT_W-1:0]  bit_q;
   logic [EPI_BYTE_W-1:0] rx_sh_q, rx_word;
   logic                  rx_push;
   assign rx_word = {rx_sh_q[EPI_BYTE_W-2:0], sdi_s};
   assign rx_push = live & sck_rise & (bit_q == EPI_LAST_BIT);

   // Bits enter MSB first on each clock rise, counter cleared on select.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q   <= '0;
         rx_sh_q <= EPI_BYTE_RST;
      end else if (!active_q) begin
         bit_q   <= '0;
      end else if (live && sck_rise) begin
         rx_sh_q <= rx_word;
         bit_q   <= bit_q + 1'b1;
      end
   end

   // ==========================================================
   // Two-entry receive buffer
   // ==========================================================
   logic [EPI_BYTE_W-1:0] head_q, skid_q;
   logic                  head_v_q, skid_v_q, pop;
   assign pop = head_v_q & rx_ready;

   // The head register feeds the port; the skid catches a stalled word.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         head_q     <= EPI_BYTE_RST;
         skid_q     <= EPI_BYTE_RST;
         head_v_q   <= 1'b0;
         skid_v_q   <= 1'b0;
         rx_overrun <= 1'b0;
      end else begin
         rx_overrun <= rx_push & skid_v_q & ~pop;
         if (pop) begin
            head_v_q <= skid_v_q | rx_push;
            head_q   <= skid_v_q ? skid_q : rx_word;
            skid_v_q <= skid_v_q & rx_push;
            if (rx_push) begin
               skid_q <= rx_word;
            end
         end else if (rx_push) begin
            if (!head_v_q) begin
               head_q   <= rx_word;
               head_v_q <= 1'b1;
            end else if (!skid_v_q) begin
               skid_q   <= rx_word;
               skid_v_q <= 1'b1;
            end
         end
      end
   end
   assign rx_data  = head_q;
   assign rx_valid = head_v_q;

   // ==========================================================
   // Transmit path
   // ==========================================================
   logic [EPI_BYTE_W-1:0] tx_hold_q, tx_sh_q;
   logic                  tx_full_q, tx_on_q, tx_take, tx_load;
   assign tx_take = tx_valid & tx_ready;
   assign tx_load = live & sck_fall & (bit_q == '0) & tx_full_q;

   // One-word holding register toward the shifter.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold_q <= EPI_BYTE_RST;
         tx_full_q <= 1'b0;
         tx_ready  <= 1'b0;
      end else begin
         if (tx_take) begin
            tx_hold_q <= tx_data;
         end
         tx_full_q <= (tx_full_q & ~tx_load) | tx_take;
         tx_ready  <= ~((tx_full_q & ~tx_load) | tx_take);
      end
   end

   // Output changes only after a clock fall, first bit at byte start.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_q <= EPI_BYTE_RST;
         tx_on_q <= 1'b0;
      end else if (!active_q) begin
         tx_on_q <= 1'b0;
      end else if (live && sck_fall) begin
         if (bit_q == '0) begin
            tx_sh_q <= tx_hold_q;
            tx_on_q <= tx_full_q;
         end else begin
            tx_sh_q <= {tx_sh_q[EPI_BYTE_W-2:0], 1'b0};
         end
      end
   end

   // Pin output and its enable.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins.sdo_o  <= EPI_PIN_IDLE;
         pins.sdo_oe <= 1'b0;
      end else begin
         pins.sdo_o  <= tx_sh_q[EPI_BYTE_W-1];
         // Deselect, hold and pause all release the line.
         pins.sdo_oe <= tx_on_q & ~cs_s & hold_s & live;
      end
   end

   // ==========================================================
   // Write launch and protection
   // ==========================================================
   // Select rising after a complete write sequence launches it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_start <= 1'b0;
      end else begin
         write_start <= cs_rise & active_q & write_armed & ~write_busy;
      end
   end

   // Frozen while a write runs so the pin cannot disturb it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_write_ok <= 1'b1;
      end else if (!write_busy && !write_start) begin
         status_write_ok <= ~status_protect_enable | wp_s;
      end
   end

   // Standby waits for a running program cycle to end and is left
   // by a select fall seen after power-up, or by write_busy going high.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         standby <= 1'b1;
         paused  <= 1'b0;
      end else begin
         standby <= ~active_q & ~write_busy;
         paused  <= paused_q;
      end
   end
endmodule // epi_dev

// ---- epi_host.sv ----
// Master end of the serial pin link; makes the serial clock itself.
`timescale 1ns/1ps
module epi_host
   import epi_pkg::*;
(
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   // Link pins
   epi_if.host                            pins,
   // Bytes to send; last closes the frame
   input  wire logic [epi_pkg::EPI_BYTE_W-1:0] tx_data,
   input  wire logic                      tx_last,
   input  wire logic                      tx_valid,
   output logic                           tx_ready,
   // Bytes read back
   output logic [epi_pkg::EPI_BYTE_W-1:0] rx_data,
   output logic                           rx_valid,
   // Pause request and protect level
   input  wire logic                      hold_req,
   input  wire logic                      protect_req,
   output logic                           busy
);
   import epi_pkg::*;

   // ==========================================================
   // Returned data synchroniser
   // ==========================================================
   logic sdo_m_q, sdo_s_q;

   // Two flip-flops before the sampler reads the device output.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_m_q <= EPI_PIN_IDLE;
         sdo_s_q <= EPI_PIN_IDLE;
      end else begin
         sdo_m_q <= pins.sdo;
         sdo_s_q <= sdo_m_q;
      end
   end

   // ==========================================================
   // Frame sequencer
   // ==========================================================
   epi_hstate_e           st_q;
   logic [7:0]            tmr_q;
   logic [EPI_CNT_W-1:0]  bit_q;
   logic [EPI_BYTE_W-1:0] sh_q, in_q;
   logic                  last_q, done, take;
   assign done = (tmr_q == EPI_HALF_CYC - 8'h01);
   assign take = tx_valid & tx_ready;

   // Timer runs except in idle, between bytes, and while paused in clock-low.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= 8'h00;
      end else if (done || st_q == EPI_H_IDLE || st_q == EPI_H_NEXT) begin
         tmr_q <= 8'h00;
      end else if (!(st_q == EPI_H_LOW && !pins.hold_n)) begin
         tmr_q <= tmr_q + 8'h01;
      end
   end

   // Pause and resume change only while the clock is low, never at
   // the edge that raises the clock.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins.hold_n <= EPI_PIN_IDLE;
      end else if (st_q == EPI_H_LOW && !done) begin
         pins.hold_n <= ~hold_req;
      end else if (st_q == EPI_H_IDLE) begin
         pins.hold_n <= EPI_PIN_IDLE;
      end
   end

   // Main sequence: lead, eight clocked bits per byte, tail.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= EPI_H_IDLE;
         pins.cs_n <= EPI_PIN_IDLE;
         pins.sck  <= 1'b0;
         pins.sdi  <= 1'b0;
         bit_q     <= '0;
         sh_q      <= EPI_BYTE_RST;
         in_q      <= EPI_BYTE_RST;
         last_q    <= 1'b0;
         rx_valid  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         case (st_q)
            EPI_H_IDLE, EPI_H_NEXT: begin
               if (take) begin
                  sh_q      <= tx_data;
                  last_q    <= tx_last;
                  bit_q     <= '0;
                  pins.cs_n <= 1'b0;
                  st_q      <= (st_q == EPI_H_IDLE) ? EPI_H_LEAD : EPI_H_LOW;
                  pins.sdi  <= tx_data[EPI_BYTE_W-1];
               end
            end
            EPI_H_LEAD: begin
               if (done) begin
                  st_q <= EPI_H_LOW;
               end
            end
            EPI_H_LOW: begin
               // Select stays low across any pause.
               if (done && pins.hold_n) begin
                  pins.sck <= 1'b1;
                  st_q     <= EPI_H_HIGH;
               end
            end
            EPI_H_HIGH: begin
               if (done) begin
                  pins.sck <= 1'b0;
                  in_q     <= {in_q[EPI_BYTE_W-2:0], sdo_s_q};
                  sh_q     <= {sh_q[EPI_BYTE_W-2:0], 1'b0};
                  pins.sdi <= sh_q[EPI_BYTE_W-2];
                  bit_q    <= bit_q + 1'b1;
                  if (bit_q == EPI_LAST_BIT) begin
                     rx_valid <= 1'b1;
                     st_q <= last_q ? EPI_H_TAIL : EPI_H_NEXT;
                  end else begin
                     st_q <= EPI_H_LOW;
                  end
               end
            end
            EPI_H_TAIL: begin
               if (done) begin
                  pins.cs_n <= EPI_PIN_IDLE;
                  st_q      <= EPI_H_IDLE;
               end
            end
            default: st_q <= EPI_H_IDLE;
         endcase
      end
   end
   assign rx_data = in_q;

   // Ready only in idle or between bytes, not in the cycle after one is taken.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready     <= 1'b0;
         busy         <= 1'b0;
         pins.wp_n    <= EPI_PIN_IDLE;
      end else begin
         tx_ready  <= (st_q == EPI_H_IDLE || st_q == EPI_H_NEXT) & ~take
                      | (st_q == EPI_H_HIGH && done
                         && bit_q == EPI_LAST_BIT && !last_q);
         busy      <= (st_q != EPI_H_IDLE) | take;
         pins.wp_n <= ~protect_req;
      end
   end
endmodule // epi_host

// ---- epi_chk.sv ----
// Concurrent checks on the serial pins between the host and EEPROM end.
`timescale 1ns/1ps
module epi_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   // ==========================================================
   // Defaults
   // ==========================================================
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Device side
   // ==========================================================
   // The output is released soon after select goes high.
   a_desel_quiet: assert property (cs_n [*6] |-> !sdo_oe)
      else $error("output driven while deselected");
   // Hold low always releases the output.
   a_hold_quiet: assert property (!hold_n [*6] |-> !sdo_oe)
      else $error("output driven while hold low");
   // Output bits change only well inside a clock low phase.
   a_sdo_timing: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o)
      |-> !sck && !$past(sck, 3))
      else $error("output changed outside clock low phase");
   // Driving starts only while selected, not held, with clock low.
   a_drive_start: assert property ($rose(sdo_oe) |-> !cs_n && hold_n && !sck)
      else $error("output enabled at a wrong moment");

   // ==========================================================
   // Host side
   // ==========================================================
   // Select leads the first clock rise by at least eight cycles.
   a_lead_gap: assert property ($fell(cs_n) |-> !sck [*8])
      else $error("clock moved too soon after select");
   // Each high phase lasts eight cycles, so input bits stand.
   a_high_phase: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
      else $error("clock high phase not eight cycles");
   // Data toward the device changes only while the clock is low.
   a_sdi_settle: assert property ($changed(sdi) |-> !sck)
      else $error("input data changed with clock high");
   // The clock stands still while deselected.
   a_idle_clock: assert property (cs_n |-> !sck)
      else $error("clock running while deselected");
   // Hold falls and rises only with the clock low.
   a_hold_fall_low: assert property ($fell(hold_n) |-> !sck)
      else $error("hold fell with clock high");
   a_hold_rise_low: assert property ($rose(hold_n) |-> !sck)
      else $error("hold rose with clock high");
   // Select stays low across a pause.
   a_hold_select: assert property (!hold_n |-> !cs_n)
      else $error("deselected during pause");
   // Clock and data freeze during a pause.
   a_pause_freeze: assert property (!hold_n && !$past(hold_n)
      |-> $stable(sck) && $stable(sdi))
      else $error("pins moved during pause");

   // Main scenarios seen.
   c_frame_end: cover property ($rose(cs_n));
   c_pause: cover property ($fell(hold_n));
   c_drive: cover property ($rose(sdo_oe));
   c_protect: cover property ($fell(wp_n));
endmodule // epi_chk

// ---- tb_eeprom_spi_pin_interface.sv ----
// Self-checking bench joining both ends of the EEPROM pin link.
`timescale 1ns/1ps
module tb_eeprom_spi_pin_interface;
   import epi_pkg::*;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        ref_clk, rst_n, h_tx_last, h_tx_valid, h_tx_ready;
   logic        h_rx_valid, hold_req, protect_req, h_busy, h_idle;
   logic        d_rx_valid, d_rx_ready, d_rx_overrun, d_tx_valid;
   logic        d_tx_ready, write_armed, write_busy, prot_en;
   logic        write_start, write_ok, standby, paused;
   logic        f_rx_valid, f_paused;
   logic [7:0]  h_tx_data, h_rx_data, d_rx_data, d_tx_data, f_rx_data;
   logic [7:0]  h_rx_last;
   logic [15:0] wire_sdi, wire_sdo;
   int          fail_count, checks_done, ws_count, ov_count;

   epi_if link_if ();
   epi_if flt_if ();
   epi_host epi_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(link_if),
      .tx_data(h_tx_data), .tx_last(h_tx_last), .tx_valid(h_tx_valid),
      .tx_ready(h_tx_ready), .rx_data(h_rx_data), .rx_valid(h_rx_valid),
      .hold_req(hold_req), .protect_req(protect_req), .busy(h_busy));
   epi_dev epi_dev_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(link_if),
      .rx_data(d_rx_data), .rx_valid(d_rx_valid), .rx_ready(d_rx_ready),
      .rx_overrun(d_rx_overrun), .tx_data(d_tx_data), .tx_valid(d_tx_valid),
      .tx_ready(d_tx_ready), .write_armed(write_armed),
      .write_busy(write_busy), .status_protect_enable(prot_en),
      .write_start(write_start), .status_write_ok(write_ok),
      .standby(standby), .paused(paused));
   // Second device end, its pins driven by the bench to break rules.
   epi_dev epi_dev_b_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(flt_if),
      .rx_data(f_rx_data), .rx_valid(f_rx_valid), .rx_ready(1'b0),
      .rx_overrun(), .tx_data(8'h00), .tx_valid(1'b0), .tx_ready(),
      .write_armed(write_armed), .write_busy(write_busy),
      .status_protect_enable(prot_en), .write_start(),
      .status_write_ok(), .standby(), .paused(f_paused));
   epi_chk epi_chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link_if.cs_n),
      .sck(link_if.sck), .sdi(link_if.sdi), .hold_n(link_if.hold_n),
      .wp_n(link_if.wp_n), .sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe));

   assign h_idle = !h_busy && link_if.cs_n;

   // Clock source, 25 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Wire monitors: bits in at clock rise, bits out before clock fall.
   always @(posedge link_if.sck) wire_sdi = {wire_sdi[14:0], link_if.sdi};
   always @(negedge link_if.sck) wire_sdo = {wire_sdo[14:0], link_if.sdo};

   // Pulse counters and last byte read back by the host.
   always @(posedge ref_clk) begin
      if (h_rx_valid) h_rx_last <= h_rx_data;
      if (write_start) ws_count <= ws_count + 1;
      if (d_rx_overrun) ov_count <= ov_count + 1;
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Waits a bounded time for a flag to go high.
   task automatic wait_hi(ref logic s, input string what);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      chk(what, 16'h1, {15'h0, s});
   endtask

   task automatic host_send(input logic [7:0] b, input logic last);
      wait_hi(h_tx_ready, "host ready");
      h_tx_data = b;
      h_tx_last = last;
      h_tx_valid = 1'b1;
      tick(1);
      h_tx_valid = 1'b0;
   endtask

   // Sends n bytes, top first, and waits for the frame to close.
   task automatic host_frame(input logic [23:0] bytes, input int n);
      wire_sdi = 16'h0;
      wire_sdo = 16'h0;
      for (int i = n - 1; i >= 0; i--) host_send(bytes[8*i +: 8], i == 0);
      tick(40);
      chk("standby in frame", 16'h0, {15'h0, standby});
      wait_hi(h_idle, "host idle");
   endtask

   task automatic pop(input logic [7:0] exp);
      chk("rx valid", 16'h1, {15'h0, d_rx_valid});
      chk("rx byte", {8'h0, exp}, {8'h0, d_rx_data});
      d_rx_ready = 1'b1;
      tick(1);
      d_rx_ready = 1'b0;
      tick(1);
   endtask

   task automatic f_phase(input logic v);
      flt_if.sck = v;
      tick(8);
   endtask

   task automatic f_bits(input logic [7:0] b, input int hi, input int lo);
      for (int i = hi; i >= lo; i--) begin
         flt_if.sdi = b[i];
         f_phase(1'b0);
         f_phase(1'b1);
      end
      f_phase(1'b0);
   endtask

   // Hands one byte to the device end for its next output byte.
   task automatic dev_load(input logic [7:0] b);
      wait_hi(d_tx_ready, "dev ready");
      d_tx_data = b;
      d_tx_valid = 1'b1;
      tick(1);
      d_tx_valid = 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_stream();
      dev_load(8'hc3);
      host_frame(24'h005a81, 2);
      chk("sdi wire", 16'h5a81, wire_sdi);
      chk("sdo wire", 16'hffc3, wire_sdo);
      chk("host rx", 16'h00c3, {8'h0, h_rx_last});
      pop(8'h5a);
      pop(8'h81);
      chk("rx empty", 16'h0, {15'h0, d_rx_valid});
      chk("standby after", 16'h1, {15'h0, standby});
   endtask

   task automatic t_overrun();
      host_frame(24'h112233, 3);
      chk("overruns", 16'h1, ov_count[15:0]);
      chk("undriven rx", 16'h00ff, {8'h0, h_rx_last});
      pop(8'h11);
      pop(8'h22);
      chk("rx drained", 16'h0, {15'h0, d_rx_valid});
   endtask

   task automatic t_write();
      write_armed = 1'b1;
      host_frame(24'h000006, 1);
      tick(10);
      chk("write starts", 16'h1, ws_count[15:0]);
      pop(8'h06);
      write_busy = 1'b1;
      host_frame(24'h000002, 1);
      tick(10);
      chk("no start busy", 16'h1, ws_count[15:0]);
      chk("standby busy", 16'h0, {15'h0, standby});
      write_busy = 1'b0;
      tick(6);
      chk("standby done", 16'h1, {15'h0, standby});
      write_armed = 1'b0;
      pop(8'h02);
   endtask

   task automatic t_protect();
      for (int i = 0; i < 4; i++) begin
         prot_en = i[1];
         protect_req = i[0];
         tick(10);
         chk("writable", {15'h0, !(i[1] && i[0])}, {15'h0, write_ok});
      end
      protect_req = 1'b0;
      tick(10);
      write_busy = 1'b1;
      protect_req = 1'b1;
      tick(10);
      chk("writable in write", 16'h1, {15'h0, write_ok});
      write_busy = 1'b0;
      tick(10);
      chk("writable after", 16'h0, {15'h0, write_ok});
      prot_en = 1'b0;
      protect_req = 1'b0;
   endtask

   task automatic t_hold();
      dev_load(8'ha6);
      host_send(8'h96, 1'b0);
      host_send(8'h69, 1'b1);
      tick(30);
      chk("sdo before pause", 16'h1, {15'h0, link_if.sdo_oe});
      hold_req = 1'b1;
      wait_hi(paused, "paused");
      tick(8);
      chk("sdo in pause", 16'h0, {15'h0, link_if.sdo_oe});
      chk("select in pause", 16'h0, {15'h0, link_if.cs_n});
      hold_req = 1'b0;
      tick(40);
      wait_hi(h_idle, "host idle");
      chk("host rx held", 16'h00a6, {8'h0, h_rx_last});
      pop(8'h96);
      pop(8'h69);
   endtask

   task automatic t_fault();
      f_bits(8'ha5, 7, 0);
      chk("no early byte", 16'h0, {15'h0, f_rx_valid});
      flt_if.cs_n = 1'b1;
      tick(8);
      flt_if.cs_n = 1'b0;
      tick(8);
      f_bits(8'h3c, 7, 5);
      flt_if.sdi = 1'b1;
      f_phase(1'b1);
      flt_if.hold_n = 1'b0;
      tick(8);
      chk("pause clock high", 16'h0, {15'h0, f_paused});
      f_phase(1'b0);
      chk("pause at fall", 16'h1, {15'h0, f_paused});
      chk("sdo paused", 16'h0, {15'h0, flt_if.sdo_oe});
      flt_if.sdi = 1'b0;
      f_phase(1'b1);
      flt_if.hold_n = 1'b1;
      tick(8);
      chk("resume clock high", 16'h1, {15'h0, f_paused});
      flt_if.hold_n = 1'b0;
      f_phase(1'b0);
      flt_if.hold_n = 1'b1;
      tick(8);
      chk("resume clock low", 16'h0, {15'h0, f_paused});
      f_bits(8'h3c, 3, 0);
      chk("kept byte", 16'h013c, {7'h0, f_rx_valid, f_rx_data});
      flt_if.cs_n = 1'b1;
   endtask

   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      {rst_n, h_tx_last, h_tx_valid, hold_req, protect_req} = 5'h00;
      {d_rx_ready, d_tx_valid, write_armed, write_busy, prot_en} = 5'h00;
      {h_tx_data, d_tx_data} = 16'h0000;
      {flt_if.cs_n, flt_if.sck, flt_if.sdi} = 3'h0;
      {flt_if.hold_n, flt_if.wp_n} = 2'h3;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      tick(2);
      chk("standby reset", 16'h1, {15'h0, standby});
      chk("sdo reset", 16'h0, {15'h0, link_if.sdo_oe});
      t_stream();
      t_overrun();
      t_write();
      t_protect();
      t_hold();
      t_fault();
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      tally_and_finish();
   end
endmodule // tb_eeprom_spi_pin_interface
